/* cmrc_pkg.sv */
/*
  Constants, types and register map of the charger mode and reset control block.
  Assumes a single 40 MHz clock and a classic Wishbone slave with 32-bit data.
*/
`default_nettype none

package cmrc_pkg;

  // ==========================================================================
  // Clock and times
  localparam int unsigned CLK_MHZ           = 40;
  localparam int unsigned RST_FILTER_MIN_US = 1500;
  localparam int unsigned RST_FILTER_MAX_US = 4000;
  localparam int unsigned ARP_CLEAR_MS      = 2000;
  localparam int unsigned ARP_CLEAR_MIN_MS  = 1600;
  localparam int unsigned ARP_CLEAR_MAX_MS  = 2400;
  localparam int unsigned OFF_HOLD_MS       = 2400;
  localparam int unsigned RESET_HOLD_CYC    = 16;
  localparam int unsigned ERR_MARGIN_MV     = 50;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CHG_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FAST_THR   = 8'h04;
  localparam logic [7:0] OFS_FLOAT_THR  = 8'h08;
  localparam logic [7:0] OFS_CHG_STAT   = 8'h0C;
  localparam logic [7:0] OFS_RST_CTRL   = 8'h10;
  localparam logic [7:0] OFS_RST_STAT   = 8'h14;
  localparam logic [7:0] OFS_BRK_TMO    = 8'h18;
  localparam logic [7:0] OFS_WDOG_LOAD  = 8'h1C;
  localparam logic [7:0] OFS_WDOG_KICK  = 8'h20;
  localparam logic [7:0] OFS_BAUD       = 8'h24;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned F_CHG_EN      = 0;
  localparam int unsigned F_IFAST_LSB   = 8;
  localparam int unsigned F_HYST_LSB    = 16;
  localparam int unsigned F_CV          = 4;
  localparam int unsigned F_REG_LATCH   = 0;
  localparam int unsigned F_XTAL_LSB    = 4;
  localparam int unsigned F_WARM        = 3;
  localparam int unsigned F_ARP         = 4;
  localparam logic [7:0]  IFAST_MIN_MA  = 8'h0A;
  localparam logic [7:0]  IFAST_MAX_MA  = 8'hC8;
  localparam logic [7:0]  IFAST_RST     = 8'h64;
  localparam logic [7:0]  TERM_DIV      = 8'h0A;
  localparam logic [11:0] VFAST_RST     = 12'hBB8;
  localparam logic [11:0] VFAST_HYS_RST = 12'h064;
  localparam logic [11:0] VFLOAT_RST    = 12'hFA0;
  localparam logic [11:0] VHYST_RST     = 12'h096;
  localparam logic [1:0]  XTAL_MAX_SEL  = 2'h3;
  localparam logic [31:0] BAUD_RST      = 32'h0001C200;
  localparam logic [31:0] BRK_TMO_RST   = 32'h00010000;
  localparam int unsigned PAD_N         = 23;
  // Pad indices: 0 tx, 1 rx, 2 cts, 3 rts, 4 spi cs, 5-7 spi, 8 reset, 9-12 audio, 13-22 pio
  localparam logic [22:0] PULL_WEAK_PU  = 23'h000001;
  localparam logic [22:0] PULL_STR_PU   = 23'h00011A;
  localparam logic [22:0] PULL_WEAK_PD  = 23'h7FFEE4;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    CHG_DISABLED, CHG_TRICKLE, CHG_FAST, CHG_STANDBY, CHG_ERROR
  } cmrc_chg_mode_e;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_PIN, CAUSE_POR, CAUSE_USB, CAUSE_BREAK, CAUSE_WDOG
  } cmrc_cause_e;

  typedef enum logic [1:0] {RS_RUN, RS_RESET, RS_OFF} cmrc_rst_state_e;

  typedef struct packed {
    logic [11:0] battery_sense_mv;
    logic [11:0] charger_supply_mv;
    logic [7:0]  charge_current_ma;
  } cmrc_sense_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cmrc_wb_req_s;

  typedef struct packed {
    logic [22:0] weak_pu;
    logic [22:0] strong_pu;
    logic [22:0] weak_pd;
  } cmrc_pull_s;

endpackage : cmrc_pkg

`default_nettype wire

/* cmrc_top.sv */
/*
  Charger mode selection and reset control, with a Wishbone register slave.
  Assumes all inputs synchronous to clk and analogue values given in mV and mA.
*/
// Summary of operation
// R1: Charger starts disabled until firmware enables
// R2: Exactly five charger modes encoded
// R3: Below fast threshold select trickle, tenth current
// R4: Fast threshold comparison has hysteresis
// R5: Above fast threshold, fast mode 10-200mA
// R6: Constant current until float, then voltage
// R7: Current below termination moves to standby
// R8: Standby returns fast below float minus hysteresis
// R9: Sense above supply minus 50mV: error
// R10: Error clears by itself, no reset
// R11: Mode transitions evaluated every cycle
// R12: Five reset sources accepted
// R13: Pin filtered, reset 1.5 to 4ms
// R14: Host holds pin low over 5ms
// R15: In reset, pads become inputs
// R16: Reset-time pulls per pad group
// R17: Clock selection resets to maximum crystal
// R18: Warm keeps baud and RAM; cold not
// R19: Protection restarts, clears after about 2s
// R20: Pin low beyond 2.4s turns off
// R21: Wake only on enable or supply rise
// R22: Break counts after configurable low timeout
// R23: UART pads tristate while held in reset
// R24: Regulator enable input turns regulators on, latchable
// R25: Priority disabled, error, standby, fast, trickle
// R26: Last reset cause and warm flag reported
`default_nettype none

module cmrc_top #(
  parameter int unsigned RST_FILTER_CYCLES = cmrc_pkg::RST_FILTER_MIN_US * cmrc_pkg::CLK_MHZ,
  parameter int unsigned ARP_CLEAR_CYCLES  = cmrc_pkg::ARP_CLEAR_MS * 1000 * cmrc_pkg::CLK_MHZ,
  parameter int unsigned OFF_HOLD_CYCLES   = cmrc_pkg::OFF_HOLD_MS * 1000 * cmrc_pkg::CLK_MHZ
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire cmrc_pkg::cmrc_wb_req_s wb_req,
  output var  logic [31:0]           wb_dat_o,
  output var  logic                  wb_ack_o,
  input  wire cmrc_pkg::cmrc_sense_s sense,
  input  wire logic                  reset_pin_n,
  input  wire logic                  power_on_reset_in,
  input  wire logic                  charger_supply_in,
  input  wire logic                  regulator_enable_in,
  input  wire logic                  uart_receive_line,
  input  wire logic [22:0]           func_oe,
  output var  logic [22:0]           pad_oe,
  output var  cmrc_pkg::cmrc_pull_s  pad_pull,
  output var  logic [2:0]            charger_mode,
  output var  logic [7:0]            charge_current_set_ma,
  output var  logic                  charge_cv_regulate,
  output var  logic                  chip_reset,
  output var  logic                  ram_retain,
  output var  logic [31:0]           baud_rate,
  output var  logic [1:0]            crystal_input_sel,
  output var  logic                  regulator_on
);
  import cmrc_pkg::*;

  // ==========================================================================
  // Register state
  logic             chg_en;
  logic [7:0]       ifast;
  logic [11:0]      vfast, vfast_hys, vfloat, vhyst;
  logic             reg_latch;
  logic [31:0]      brk_tmo, wdog_load, wdog_cnt;
  logic [31:0]      pin_low_cnt, brk_cnt, arp_cnt;
  logic [4:0]       hold_cnt;
  cmrc_chg_mode_e   mode, next_mode;
  cmrc_rst_state_e  rstate;
  cmrc_cause_e      cause, req_cause;
  logic             warm, cv, cold_start;
  logic             supply_d, regen_d;
  logic             wb_hit, wr_en, rd_ack;
  logic [31:0]      rd_data;
  logic [31:0]      fast_thr_m, float_thr_m;

  assign wb_hit = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign wr_en  = wb_hit && wb_req.we;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Byte-lane merged threshold words, sliced into the fields below
  assign fast_thr_m  = merge({4'h0, vfast_hys, 4'h0, vfast}, wb_req.dat, wb_req.sel);
  assign float_thr_m = merge({4'h0, vhyst, 4'h0, vfloat}, wb_req.dat, wb_req.sel);

  // ==========================================================================
  // Wishbone slave: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_req.we) wb_dat_o <= rd_data;
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    case (wb_req.adr)
      OFS_CHG_CTRL:  rd_data = {16'h0000, ifast, 7'h00, chg_en};
      OFS_FAST_THR:  rd_data = {4'h0, vfast_hys, 4'h0, vfast};
      OFS_FLOAT_THR: rd_data = {4'h0, vhyst, 4'h0, vfloat};
      OFS_CHG_STAT:  rd_data = {27'h0000000, cv, 1'b0, mode};               // see R2
      OFS_RST_CTRL:  rd_data = {26'h0000000, crystal_input_sel, 3'h0, reg_latch};
      OFS_RST_STAT:  rd_data = {27'h0000000, arp_cnt != 32'h0, warm, cause}; // see R26
      OFS_BRK_TMO:   rd_data = brk_tmo;
      OFS_WDOG_LOAD: rd_data = wdog_load;
      OFS_BAUD:      rd_data = baud_rate;
      default:       rd_data = 32'h00000000;
    endcase
  end

  // Charger settings; a cold start drops the enable so charging waits for firmware
  always_ff @(posedge clk) begin
    if (srst || cold_start) begin
      chg_en <= 1'b0;                                                       // see R1
      ifast  <= IFAST_RST;
    end else if (wr_en && wb_req.adr == OFS_CHG_CTRL) begin
      if (wb_req.sel[0]) chg_en <= wb_req.dat[F_CHG_EN];
      if (wb_req.sel[1]) begin
        // Clamp into the supported fast current range
        if (wb_req.dat[F_IFAST_LSB +: 8] < IFAST_MIN_MA) ifast <= IFAST_MIN_MA;    // see R5
        else if (wb_req.dat[F_IFAST_LSB +: 8] > IFAST_MAX_MA) ifast <= IFAST_MAX_MA;
        else ifast <= wb_req.dat[F_IFAST_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vfast     <= VFAST_RST;
      vfast_hys <= VFAST_HYS_RST;
      vfloat    <= VFLOAT_RST;
      vhyst     <= VHYST_RST;
    end else if (wr_en && wb_req.adr == OFS_FAST_THR) begin
      {vfast_hys, vfast} <= {fast_thr_m[27:16], fast_thr_m[11:0]};
    end else if (wr_en && wb_req.adr == OFS_FLOAT_THR) begin
      {vhyst, vfloat} <= {float_thr_m[27:16], float_thr_m[11:0]};
    end
  end

  // Crystal selection returns to the maximum crystal setting on any chip reset
  always_ff @(posedge clk) begin
    if (srst || chip_reset) begin
      crystal_input_sel <= XTAL_MAX_SEL;                                    // see R17
    end else if (wr_en && wb_req.adr == OFS_RST_CTRL && wb_req.sel[0]) begin
      crystal_input_sel <= wb_req.dat[F_XTAL_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst || rstate == RS_OFF) begin
      reg_latch <= 1'b0;
    end else if (wr_en && wb_req.adr == OFS_RST_CTRL && wb_req.sel[0]) begin
      reg_latch <= wb_req.dat[F_REG_LATCH];                                 // see R24
    end
  end

  // Baud rate survives a warm reset only
  always_ff @(posedge clk) begin
    if (srst || cold_start) begin
      baud_rate <= BAUD_RST;                                                // see R18
    end else if (wr_en && wb_req.adr == OFS_BAUD) begin
      baud_rate <= merge(baud_rate, wb_req.dat, wb_req.sel);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      brk_tmo <= BRK_TMO_RST;
    end else if (wr_en && wb_req.adr == OFS_BRK_TMO) begin
      brk_tmo <= merge(brk_tmo, wb_req.dat, wb_req.sel);
    end
  end

  // ==========================================================================
  // Charger mode selection, re-evaluated every cycle
  logic [12:0] vs13;
  logic        err_cond, above_fast, below_fast_hys, recharge, at_float, term;

  assign vs13           = {1'b0, sense.battery_sense_mv};
  assign err_cond       = (vs13 + 13'(ERR_MARGIN_MV)) > {1'b0, sense.charger_supply_mv}; // see R9
  assign above_fast     = vs13 > {1'b0, vfast};
  assign below_fast_hys = (vs13 + {1'b0, vfast_hys}) < {1'b0, vfast};     // see R4
  assign recharge       = (vs13 + {1'b0, vhyst}) < {1'b0, vfloat};        // see R8
  assign at_float       = vs13 >= {1'b0, vfloat};
  assign term           = sense.charge_current_ma < (ifast / TERM_DIV);   // see R7

  always_comb begin
    next_mode = mode;
    if (!chg_en) begin
      next_mode = CHG_DISABLED;                                             // see R25
    end else if (err_cond) begin
      next_mode = CHG_ERROR;                                                // see R9
    end else begin
      case (mode)
        CHG_STANDBY: next_mode = recharge ? CHG_FAST : CHG_STANDBY;         // see R8
        CHG_FAST: begin
          if (cv && term) next_mode = CHG_STANDBY;                          // see R7
          else if (below_fast_hys) next_mode = CHG_TRICKLE;                 // see R4
          else next_mode = CHG_FAST;
        end
        CHG_TRICKLE: next_mode = above_fast ? CHG_FAST : CHG_TRICKLE;       // see R3
        // Leaving error or disabled needs no reset, only the conditions
        default: next_mode = above_fast ? CHG_FAST : CHG_TRICKLE;           // see R10
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) mode <= CHG_DISABLED;                                         // see R1
    else mode <= next_mode;                                                 // see R11
  end

  // Constant voltage phase latches once float is reached inside fast mode
  always_ff @(posedge clk) begin
    if (srst || next_mode != CHG_FAST) cv <= 1'b0;
    else if (at_float) cv <= 1'b1;                                          // see R6
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      charge_current_set_ma <= 8'h00;
    end else begin
      case (next_mode)
        CHG_TRICKLE: charge_current_set_ma <= ifast / TERM_DIV;             // see R3
        CHG_FAST:    charge_current_set_ma <= ifast;                        // see R5
        default:     charge_current_set_ma <= 8'h00;
      endcase
    end
  end

  assign charger_mode       = mode;
  assign charge_cv_regulate = cv;

  // ==========================================================================
  // Reset sources
  logic pin_req, brk_req, wdog_req, usb_req, any_req, pin_off;

  always_ff @(posedge clk) begin
    if (srst || reset_pin_n) pin_low_cnt <= 32'h0;
    else if (pin_low_cnt <= 32'(OFF_HOLD_CYCLES)) pin_low_cnt <= pin_low_cnt + 32'h1; // see R13
  end

  // Pin counts as a request once it has stayed low for the filter time
  assign pin_req = !reset_pin_n && pin_low_cnt == 32'(RST_FILTER_CYCLES - 1);   // see R13
  assign pin_off = pin_low_cnt > 32'(OFF_HOLD_CYCLES);                          // see R20

  always_ff @(posedge clk) begin
    if (srst || uart_receive_line || chip_reset) brk_cnt <= 32'h0;
    else if (brk_cnt != brk_tmo) brk_cnt <= brk_cnt + 32'h1;                // see R22
  end
  assign brk_req = !uart_receive_line && !chip_reset && brk_tmo != 32'h0 &&
                   brk_cnt == brk_tmo - 32'h1;

  // Watchdog: a zero load disables it, a kick reloads it
  always_ff @(posedge clk) begin
    if (srst || chip_reset) begin
      wdog_load <= 32'h0;
      wdog_cnt  <= 32'h0;
    end else if (wr_en && wb_req.adr == OFS_WDOG_LOAD) begin
      wdog_load <= merge(wdog_load, wb_req.dat, wb_req.sel);
      wdog_cnt  <= merge(wdog_load, wb_req.dat, wb_req.sel);
    end else if (wr_en && wb_req.adr == OFS_WDOG_KICK) begin
      wdog_cnt <= wdog_load;
    end else if (wdog_cnt != 32'h0) begin
      wdog_cnt <= wdog_cnt - 32'h1;
    end
  end
  // Only a load or kick may mask the expiry; other register writes must not
  assign wdog_req = wdog_cnt == 32'h1 &&
                    !(wr_en && (wb_req.adr == OFS_WDOG_LOAD || wb_req.adr == OFS_WDOG_KICK));

  always_ff @(posedge clk) begin
    if (srst) begin
      supply_d <= 1'b0;
      regen_d  <= 1'b0;
    end else begin
      supply_d <= charger_supply_in;
      regen_d  <= regulator_enable_in;
    end
  end
  assign usb_req = charger_supply_in && !supply_d;

  assign any_req = pin_req || power_on_reset_in || usb_req || brk_req || wdog_req; // see R12

  always_comb begin
    if (power_on_reset_in) req_cause = CAUSE_POR;
    else if (pin_req)      req_cause = CAUSE_PIN;
    else if (usb_req)      req_cause = CAUSE_USB;
    else if (brk_req)      req_cause = CAUSE_BREAK;
    else if (wdog_req)     req_cause = CAUSE_WDOG;
    else                   req_cause = CAUSE_NONE;
  end

  // ==========================================================================
  // Reset sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      rstate   <= RS_RESET;
      cause    <= CAUSE_POR;
      warm     <= 1'b0;
      hold_cnt <= 5'(RESET_HOLD_CYC);
    end else begin
      case (rstate)
        RS_RUN: begin
          if (any_req) begin
            rstate   <= RS_RESET;
            cause    <= req_cause;                                          // see R26
            warm     <= req_cause != CAUSE_POR;                             // see R18
            hold_cnt <= 5'(RESET_HOLD_CYC);
          end
        end
        RS_RESET: begin
          if (pin_off) begin
            rstate <= RS_OFF;                                               // see R20
          end else if (hold_cnt != 5'h0) begin
            hold_cnt <= hold_cnt - 5'h1;
          end else if (reset_pin_n) begin
            rstate <= RS_RUN;                                               // see R19
          end
        end
        RS_OFF: begin
          if ((regulator_enable_in && !regen_d) || usb_req) begin           // see R21
            rstate   <= RS_RESET;
            cause    <= CAUSE_POR;
            warm     <= 1'b0;
            hold_cnt <= 5'(RESET_HOLD_CYC);
          end
        end
        default: rstate <= RS_RESET;
      endcase
    end
  end

  assign cold_start = (rstate == RS_RUN && any_req && req_cause == CAUSE_POR) ||
                      (rstate == RS_OFF && ((regulator_enable_in && !regen_d) || usb_req));

  // Protection window armed by every reset and cleared after the nominal time
  always_ff @(posedge clk) begin
    if (srst) arp_cnt <= 32'(ARP_CLEAR_CYCLES);
    else if (rstate == RS_RESET) arp_cnt <= 32'(ARP_CLEAR_CYCLES);          // see R19
    else if (arp_cnt != 32'h0) arp_cnt <= arp_cnt - 32'h1;
  end

  // ==========================================================================
  // Pads and supplies: chip logic owns the pads only outside reset
  assign chip_reset   = rstate != RS_RUN;
  assign ram_retain   = warm;                                               // see R18
  assign pad_oe       = chip_reset ? '0 : func_oe;                          // see R15 R23
  assign pad_pull     = chip_reset ? '{weak_pu: PULL_WEAK_PU, strong_pu: PULL_STR_PU,
                                       weak_pd: PULL_WEAK_PD} : '0;         // see R16
  assign regulator_on = rstate != RS_OFF &&
                        (regulator_enable_in || reg_latch || charger_supply_in); // see R24

  // ==========================================================================
  // Checks
  property p_chg_off;
    @(posedge clk) disable iff (srst) !chg_en |=> mode == CHG_DISABLED;
  endproperty
  a_chg_off: assert property (p_chg_off) else $error("charger not disabled"); // see R1

  property p_error;
    @(posedge clk) disable iff (srst) (chg_en && err_cond) |=> mode == CHG_ERROR;
  endproperty
  a_error: assert property (p_error) else $error("error mode missed"); // see R9

  property p_trickle_i;
    @(posedge clk) disable iff (srst)
      (mode == CHG_TRICKLE && $stable(ifast)) |-> charge_current_set_ma == ifast / TERM_DIV;
  endproperty
  a_trickle_i: assert property (p_trickle_i) else $error("trickle current wrong"); // see R3

  property p_pin_filter;
    @(posedge clk) disable iff (srst)
      (rstate == RS_RUN && pin_req && !power_on_reset_in) |=>
        rstate == RS_RESET && cause == CAUSE_PIN;
  endproperty
  a_pin_filter: assert property (p_pin_filter) else $error("pin reset missed"); // see R13

  property p_tristate;
    @(posedge clk) disable iff (srst) chip_reset |-> pad_oe == '0;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pad driven in reset"); // see R15

  property p_off;
    @(posedge clk) disable iff (srst) (rstate == RS_RESET && pin_off) |=> rstate == RS_OFF;
  endproperty
  a_off: assert property (p_off) else $error("long hold did not turn off"); // see R20

  property p_stay_off;
    @(posedge clk) disable iff (srst)
      (rstate == RS_OFF && !$rose(regulator_enable_in) && !usb_req) |=> rstate == RS_OFF;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("woke without edge"); // see R21

  property p_cold;
    @(posedge clk) disable iff (srst) cold_start |=> !chg_en && baud_rate == BAUD_RST && !warm;
  endproperty
  a_cold: assert property (p_cold) else $error("cold start kept state"); // see R18

  property p_hold;
    @(posedge clk) disable iff (srst) (rstate == RS_RUN && any_req) |=> chip_reset [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset too short"); // see R12

  property p_wb_ack;
    @(posedge clk) disable iff (srst) wb_hit |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

endmodule : cmrc_top

`default_nettype wire

/* cmrc_far_side.sv */
/* Far-side model: battery, charger supply and reset driver.
   Assumes targets change only just after a rising clk edge. */
`default_nettype none
module cmrc_far_side (
  input  wire logic                 clk,
  input  wire logic [11:0]          batt_mv,
  input  wire logic [11:0]          sup_mv,
  input  wire logic [7:0]           cur_ma,
  input  wire logic                 hold_low,
  output var  cmrc_pkg::cmrc_sense_s sense,
  output var  logic                 reset_pin_n,
  output var  logic                 charger_supply_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import cmrc_pkg::*;
  // ==========================================
  // Levels
  // Levels settle one edge late, like a real slow analogue source
  always_ff @(posedge clk) begin
    sense             <= '{batt_mv, sup_mv, cur_ma};
    reset_pin_n       <= !hold_low;
    charger_supply_in <= sup_mv != 12'h000;
  end
endmodule // cmrc_far_side
`default_nettype wire

/* test_charger_mode_and_reset_control.sv */
/* Bench for the charger mode and reset control block.
   Assumes the far-side model drives battery, supply and reset pin. */
`default_nettype none
module test_charger_mode_and_reset_control;
  timeunit 1ns;
  timeprecision 100ps;
  import cmrc_pkg::*;
  typedef struct packed {
    logic [11:0] b, s;
    logic [7:0]  c;
    logic [2:0]  m;
    logic [7:0]  i;
    logic        v;
  } cmrc_row_s;
  // ==========================================
  // Rows: battery, supply, current, mode, set current, constant voltage
  localparam cmrc_row_s ROWS [9] = '{
    '{12'h7D0, 12'hFFF, 8'h00, 3'h1, 8'h0A, 1'b0},
    '{12'hDAC, 12'hFFF, 8'h00, 3'h2, 8'h64, 1'b0},
    '{12'hB86, 12'hFFF, 8'h00, 3'h2, 8'h64, 1'b0},
    '{12'hFA0, 12'hFFF, 8'h32, 3'h2, 8'h64, 1'b1},
    '{12'hFA0, 12'hFFF, 8'h05, 3'h3, 8'h00, 1'b0},
    '{12'hF3C, 12'hFFF, 8'h05, 3'h3, 8'h00, 1'b0},
    '{12'hE74, 12'hFFF, 8'h05, 3'h2, 8'h64, 1'b0},
    '{12'hE74, 12'hE74, 8'h05, 3'h4, 8'h00, 1'b0},
    '{12'hE74, 12'hFFF, 8'h05, 3'h2, 8'h64, 1'b0}};
  logic clk, srst, ack, chg_in, reg_en, cr, retain, hold, cv, reg_on, urx;
  logic [31:0] rdat, baud, q;
  logic [22:0] oe;
  logic [11:0] batt, sup;
  logic [7:0] cur, cset;
  logic [2:0] mode;
  logic [1:0] xsel;
  cmrc_wb_req_s wb_req;
  cmrc_sense_s sense;
  cmrc_pull_s pull;
  logic pin_n;
  int n_errors = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  cmrc_far_side cmrc_far_side_i (.clk(clk), .batt_mv(batt), .sup_mv(sup), .cur_ma(cur),
    .hold_low(hold), .sense(sense), .reset_pin_n(pin_n), .charger_supply_in(chg_in));
  cmrc_top #(.RST_FILTER_CYCLES(20), .ARP_CLEAR_CYCLES(50), .OFF_HOLD_CYCLES(100)) cmrc_top_i (
    .clk(clk), .srst(srst), .wb_req(wb_req), .wb_dat_o(rdat), .wb_ack_o(ack), .sense(sense),
    .reset_pin_n(pin_n), .power_on_reset_in(1'b0), .charger_supply_in(chg_in),
    .regulator_enable_in(reg_en), .uart_receive_line(urx), .func_oe(23'h7FFFFF),
    .pad_oe(oe), .pad_pull(pull), .charger_mode(mode), .charge_current_set_ma(cset),
    .charge_cv_regulate(cv), .chip_reset(cr), .ram_retain(retain), .baud_rate(baud),
    .crystal_input_sel(xsel), .regulator_on(reg_on));
  // ==========================================
  // Tasks
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Samples at the edge, before that edge's updates land
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    wb_req <= '0;
    @(posedge clk);
    if (n >= 50) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (cr !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(cr, v);
  endtask
  // ==========================================
  // Sequence
  initial begin
    clk = 0; srst = 1; wb_req = '0; reg_en = 0; hold = 0; urx = 1;
    batt = 12'h7D0; sup = 12'hFFF; cur = 8'h00;
    repeat (3) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk(mode, 0);
    wait_rst(0, 40);
    wb(0, OFS_RST_STAT, 0);
    chk(q[3:0], 4'h2);
    wb(1, OFS_CHG_CTRL, 32'h6401);
    wb(1, OFS_BAUD, 32'h2580);
    wb(1, OFS_RST_CTRL, 0);
    foreach (ROWS[i]) begin
      batt <= ROWS[i].b; sup <= ROWS[i].s; cur <= ROWS[i].c;
      repeat (4) @(posedge clk);
      chk(mode, ROWS[i].m);
      chk(cset, ROWS[i].i);
      chk(cv, ROWS[i].v);
    end
    hold <= 1;
    repeat (10) @(posedge clk);
    chk(cr, 0);
    hold <= 0;
    repeat (3) @(posedge clk);
    hold <= 1;
    wait_rst(1, 25);
    chk(oe, 0);
    chk(pull, {PULL_WEAK_PU, PULL_STR_PU, PULL_WEAK_PD});
    @(posedge clk);
    chk(xsel, 3);
    hold <= 0;
    wait_rst(0, 60);
    wb(0, OFS_RST_STAT, 0);
    chk(q[3:0], 4'h9);
    chk({retain, baud}, {1'b1, 32'h2580});
    hold <= 1;
    repeat (130) @(posedge clk);
    hold <= 0;
    repeat (30) @(posedge clk);
    chk(cr, 1);
    chk(reg_on, 0);
    reg_en <= 1;
    wait_rst(0, 60);
    chk(reg_on, 1);
    chk({retain, baud}, {1'b0, BAUD_RST});
    wb(0, 8'hFC, 0);
    chk(q, 0);
    // Break: receive line held low past a short programmed timeout
    wb(1, OFS_BRK_TMO, 32'h8);
    urx <= 0;
    wait_rst(1, 20);
    urx <= 1;
    wait_rst(0, 40);
    wb(0, OFS_RST_STAT, 0);
    chk(q[3:0], 4'hC);
    wrap_up();
  end
endmodule // test_charger_mode_and_reset_control
`default_nettype wire
